// ==== pedc_pkg.sv ====
// package for the link error detection and classification block
package pedc_pkg;

	// ============================================================
	// error classes
	typedef enum logic [1:0] {
		PEDC_CLS_NONE = 2'h0,
		PEDC_CLS_COR = 2'h1,
		PEDC_CLS_NONFATAL = 2'h2,
		PEDC_CLS_FATAL = 2'h3
	} pedc_class_t;

	// ============================================================
	// lane receive status codes
	localparam logic [2:0] PEDC_RXST_DECODE = 3'h4;
	localparam logic [2:0] PEDC_RXST_EB_OVF = 3'h5;
	localparam logic [2:0] PEDC_RXST_EB_UNF = 3'h6;
	localparam logic [2:0] PEDC_RXST_DISP = 3'h7;

	// ============================================================
	// training state codes
	typedef enum logic [3:0] {
		PEDC_LT_DETECT = 4'h0,
		PEDC_LT_POLLING = 4'h1,
		PEDC_LT_CONFIG = 4'h2,
		PEDC_LT_L0 = 4'h3,
		PEDC_LT_RECOVERY = 4'h4,
		PEDC_LT_L0S = 4'h5,
		PEDC_LT_L1 = 4'h6,
		PEDC_LT_L2 = 4'h7,
		PEDC_LT_DISABLE = 4'h8,
		PEDC_LT_LOOPBACK = 4'h9,
		PEDC_LT_HOTRESET = 4'hA
	} pedc_ltssm_t;

	// ============================================================
	// status flag positions
	localparam int PEDC_NUM_ERR = 10;
	localparam int PEDC_B_RXPORT = 0;
	localparam int PEDC_B_BADTLP = 1;
	localparam int PEDC_B_BADDLLP = 2;
	localparam int PEDC_B_RPL_TMO = 3;
	localparam int PEDC_B_RPL_ROLL = 4;
	localparam int PEDC_B_POISON = 5;
	localparam int PEDC_B_TRAIN = 6;
	localparam int PEDC_B_DLPROT = 7;
	localparam int PEDC_B_DESKEW = 8;
	localparam int PEDC_B_CTLSYM = 9;
	localparam logic [PEDC_NUM_ERR-1:0] PEDC_STAT_RST = 10'h000;

	// ============================================================
	// receive packet carrier (descriptor plus payload)
	typedef struct packed {
		logic valid;
		logic poisoned;
		logic [63:0] desc;
		logic [63:0] data;
	} pedc_rx_pkt_t;

	// ============================================================
	// data link layer events
	typedef struct packed {
		logic tlp_lcrc_bad;
		logic tlp_seq_bad;
		logic dllp_crc_bad;
		logic replay_timeout;
		logic replay_rollover;
		logic ack_valid;
		logic [11:0] acknowledge_sequence_field;
	} pedc_dll_ev_t;

	// ============================================================
	// error report
	typedef struct packed {
		logic cor;
		logic nonfatal;
		logic fatal;
	} pedc_report_t;

endpackage

// ==== pedc_seq_window.sv ====
// checks an acknowledge sequence number against the outstanding window
`timescale 1ns/1ps
module pedc_seq_window #(
	parameter int SEQ_W = 12
) (
	input wire logic [SEQ_W-1:0] acked_seq,
	input wire logic [SEQ_W-1:0] next_tx_seq,
	input wire logic [SEQ_W-1:0] ack_seq,
	output logic bad
);
	logic [SEQ_W-1:0] dist_out;
	logic [SEQ_W-1:0] dist_ack;

	// modulo distances; valid ack lies in [acked_seq, next_tx_seq - 1]
	// re-acking the last acknowledged number is legal (duplicate ack)
	always_comb begin
		dist_out = next_tx_seq - acked_seq - 1'b1;
		dist_ack = ack_seq - acked_seq;
		bad = (dist_ack > dist_out);
	end
endmodule

// ==== pedc_classifier.sv ====
// link error detection and classification core
`timescale 1ns/1ps
// Functional notes
// - basic and advanced error handling both present
// - every error lands in one of three classes
// - lane status codes 100..111 in L0 flag correctable
// - deskew buffer overflow flags correctable
// - control symbol on wrong lane flags correctable
// - detect entry from illegal state is fatal
// - bad LCRC or sequence number: correctable
// - bad link packet CRC: correctable
// - replay timer expiry: correctable
// - replay counter rollover: correctable
// - unmatched acknowledge sequence number is fatal
// - poisoned packet flagged non-fatal, still delivered
module pedc_classifier
	import pedc_pkg::*;
#(
	parameter int LANES = 4,
	parameter int SEQ_W = 12,
	parameter bit TRAIN_ERR_EN = 1'b1
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [3*LANES-1:0] rx_status,
	input wire logic [LANES-1:0] lane_in_l0,
	input wire logic deskew_overflow,
	input wire logic [LANES-1:0] ctl_sym_bad_lane,
	input wire pedc_pkg::pedc_ltssm_t ltssm_state,
	input wire pedc_pkg::pedc_dll_ev_t dll_ev,
	input wire logic [SEQ_W-1:0] acked_seq,
	input wire logic [SEQ_W-1:0] next_tx_seq,
	input wire pedc_pkg::pedc_rx_pkt_t rx_pkt_in,
	input wire logic [pedc_pkg::PEDC_NUM_ERR-1:0] err_clear,
	output pedc_pkg::pedc_rx_pkt_t rx_pkt_out,
	output pedc_pkg::pedc_report_t err_report,
	output pedc_pkg::pedc_class_t err_class,
	output logic [pedc_pkg::PEDC_NUM_ERR-1:0] err_status,
	output logic [2:0] class_status
);
	import pedc_pkg::*;

	// ============================================================
	// physical layer detection
	logic [LANES-1:0] lane_err;
	logic rx_port_err;

	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			// top status bit set means one of the four error codes
			assign lane_err[g] = lane_in_l0[g] &
				rx_status[3*g+2];
		end
	endgenerate

	pedc_ltssm_t ltssm_r;
	pedc_ltssm_t ltssm_nxt;
	logic train_err;

	always_comb begin
		ltssm_nxt = ltssm_state;
		// hot reset, disable, loopback and L2 exits to detect are legal
		train_err = TRAIN_ERR_EN &&
			(ltssm_state == PEDC_LT_DETECT) &&
			(ltssm_r != PEDC_LT_DETECT) &&
			(ltssm_r != PEDC_LT_HOTRESET) &&
			(ltssm_r != PEDC_LT_DISABLE) &&
			(ltssm_r != PEDC_LT_LOOPBACK) &&
			(ltssm_r != PEDC_LT_L2);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ltssm_r <= PEDC_LT_DETECT;
		end else begin
			ltssm_r <= ltssm_nxt;
		end
	end

	// ============================================================
	// data link layer detection
	logic ack_mismatch;
	logic dl_prot_err;

	pedc_seq_window #(
		.SEQ_W(SEQ_W)
	) u_seq_window (
		.acked_seq(acked_seq),
		.next_tx_seq(next_tx_seq),
		.ack_seq(dll_ev.acknowledge_sequence_field[SEQ_W-1:0]),
		.bad(ack_mismatch)
	);

	assign dl_prot_err = dll_ev.ack_valid & ack_mismatch;

	// ============================================================
	// event vector and classification
	logic [PEDC_NUM_ERR-1:0] ev;

	always_comb begin
		ev = '0;
		rx_port_err = |lane_err;
		ev[PEDC_B_RXPORT] = rx_port_err | deskew_overflow |
			(|ctl_sym_bad_lane);
		ev[PEDC_B_DESKEW] = deskew_overflow;
		ev[PEDC_B_CTLSYM] = |ctl_sym_bad_lane;
		ev[PEDC_B_BADTLP] = dll_ev.tlp_lcrc_bad | dll_ev.tlp_seq_bad;
		ev[PEDC_B_BADDLLP] = dll_ev.dllp_crc_bad;
		ev[PEDC_B_RPL_TMO] = dll_ev.replay_timeout;
		ev[PEDC_B_RPL_ROLL] = dll_ev.replay_rollover;
		ev[PEDC_B_POISON] = rx_pkt_in.valid & rx_pkt_in.poisoned;
		ev[PEDC_B_TRAIN] = train_err;
		ev[PEDC_B_DLPROT] = dl_prot_err;
	end

	pedc_report_t rep_nxt;
	pedc_report_t rep_r;
	pedc_class_t cls_nxt;
	pedc_class_t cls_r;

	// worst class wins when several errors fire together
	always_comb begin
		rep_nxt.cor = ev[PEDC_B_RXPORT] | ev[PEDC_B_BADTLP] |
			ev[PEDC_B_BADDLLP] | ev[PEDC_B_RPL_TMO] |
			ev[PEDC_B_RPL_ROLL];
		rep_nxt.nonfatal = ev[PEDC_B_POISON];
		rep_nxt.fatal = ev[PEDC_B_TRAIN] | ev[PEDC_B_DLPROT];
		if (rep_nxt.fatal) begin
			cls_nxt = PEDC_CLS_FATAL;
		end else if (rep_nxt.nonfatal) begin
			cls_nxt = PEDC_CLS_NONFATAL;
		end else if (rep_nxt.cor) begin
			cls_nxt = PEDC_CLS_COR;
		end else begin
			cls_nxt = PEDC_CLS_NONE;
		end
	end

	// ============================================================
	// sticky status, set beats clear
	logic [PEDC_NUM_ERR-1:0] stat_r;
	logic [PEDC_NUM_ERR-1:0] stat_nxt;
	logic [2:0] cstat_r;
	logic [2:0] cstat_nxt;
	logic [2:0] cls_clr;

	always_comb begin
		stat_nxt = (stat_r & ~err_clear) | ev;
		// class summary clears only with all its member flags
		cls_clr[0] = &err_clear[4:0] & err_clear[PEDC_B_DESKEW] &
			err_clear[PEDC_B_CTLSYM];
		cls_clr[1] = err_clear[PEDC_B_POISON];
		cls_clr[2] = err_clear[PEDC_B_TRAIN] & err_clear[PEDC_B_DLPROT];
		cstat_nxt = (cstat_r & ~cls_clr) |
			{rep_nxt.fatal, rep_nxt.nonfatal, rep_nxt.cor};
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stat_r <= PEDC_STAT_RST;
			cstat_r <= 3'h0;
			rep_r <= '0;
			cls_r <= PEDC_CLS_NONE;
		end else begin
			stat_r <= stat_nxt;
			cstat_r <= cstat_nxt;
			rep_r <= rep_nxt;
			cls_r <= cls_nxt;
		end
	end

	// ============================================================
	// receive path: poisoned packets pass through untouched
	pedc_rx_pkt_t pkt_r;
	pedc_rx_pkt_t pkt_nxt;

	always_comb begin
		pkt_nxt = rx_pkt_in;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pkt_r <= '0;
		end else begin
			pkt_r <= pkt_nxt;
		end
	end

	assign rx_pkt_out = pkt_r;
	assign err_report = rep_r;
	assign err_class = cls_r;
	assign err_status = stat_r;
	assign class_status = cstat_r;

	// ============================================================
	// assertions
	poison_pass_a: assert property (
		@(posedge clk) disable iff (!resetn)
		rx_pkt_in.valid && rx_pkt_in.poisoned |=>
		rx_pkt_out.valid && rx_pkt_out.poisoned && err_report.nonfatal &&
		err_status[PEDC_B_POISON])
		else $error("poisoned packet not delivered or not flagged");

	sticky_hold_a: assert property (
		@(posedge clk) disable iff (!resetn)
		err_status[PEDC_B_BADTLP] && !err_clear[PEDC_B_BADTLP] |=>
		err_status[PEDC_B_BADTLP])
		else $error("status flag dropped without clear");

	set_wins_a: assert property (
		@(posedge clk) disable iff (!resetn)
		dll_ev.dllp_crc_bad && err_clear[PEDC_B_BADDLLP] |=>
		err_status[PEDC_B_BADDLLP])
		else $error("event lost against clear");

	train_err_a: assert property (
		@(posedge clk) disable iff (!resetn)
		$past(ltssm_state) == PEDC_LT_L0 && ltssm_state == PEDC_LT_DETECT
		&& TRAIN_ERR_EN |=> err_report.fatal && err_class == PEDC_CLS_FATAL)
		else $error("illegal detect entry not fatal");

	train_ok_a: assert property (
		@(posedge clk) disable iff (!resetn)
		$past(ltssm_state) == PEDC_LT_HOTRESET &&
		ltssm_state == PEDC_LT_DETECT && !dl_prot_err |=>
		!err_report.fatal)
		else $error("legal detect entry flagged");

	lane_code_a: assert property (
		@(posedge clk) disable iff (!resetn)
		lane_in_l0[0] && rx_status[2:0] == PEDC_RXST_EB_UNF |=>
		err_report.cor && err_status[PEDC_B_RXPORT])
		else $error("lane status error not flagged");

	deskew_a: assert property (
		@(posedge clk) disable iff (!resetn)
		deskew_overflow |=> err_status[PEDC_B_RXPORT] &&
		err_status[PEDC_B_DESKEW] && class_status[0])
		else $error("deskew overflow not flagged");

	ctl_sym_a: assert property (
		@(posedge clk) disable iff (!resetn)
		|ctl_sym_bad_lane |=> err_status[PEDC_B_CTLSYM] &&
		err_report.cor)
		else $error("control symbol error not flagged");

	bad_tlp_a: assert property (
		@(posedge clk) disable iff (!resetn)
		dll_ev.tlp_seq_bad |=> err_report.cor &&
		err_status[PEDC_B_BADTLP])
		else $error("bad packet not flagged");

	lcrc_bad_a: assert property (
		@(posedge clk) disable iff (!resetn)
		dll_ev.tlp_lcrc_bad |=> err_report.cor &&
		err_status[PEDC_B_BADTLP])
		else $error("packet check failure not flagged");

	dllp_bad_a: assert property (
		@(posedge clk) disable iff (!resetn)
		dll_ev.dllp_crc_bad |=> err_report.cor &&
		err_status[PEDC_B_BADDLLP])
		else $error("link packet check failure not flagged");

	replay_a: assert property (
		@(posedge clk) disable iff (!resetn)
		dll_ev.replay_timeout || dll_ev.replay_rollover |=>
		err_report.cor)
		else $error("replay event not flagged");

	dl_prot_a: assert property (
		@(posedge clk) disable iff (!resetn)
		dll_ev.ack_valid &&
		dll_ev.acknowledge_sequence_field[SEQ_W-1:0] == next_tx_seq |=>
		err_report.fatal && err_status[PEDC_B_DLPROT])
		else $error("unmatched ack not fatal");

	// a repeated ack of the newest acknowledged number must stay quiet
	ack_dup_a: assert property (
		@(posedge clk) disable iff (!resetn)
		dll_ev.ack_valid && !err_status[PEDC_B_DLPROT] &&
		dll_ev.acknowledge_sequence_field[SEQ_W-1:0] == acked_seq |=>
		!err_status[PEDC_B_DLPROT])
		else $error("duplicate ack flagged");

	cls_order_a: assert property (
		@(posedge clk) disable iff (!resetn)
		err_report.fatal |-> err_class == PEDC_CLS_FATAL)
		else $error("class priority wrong");

	class_nonfatal_a: assert property (
		@(posedge clk) disable iff (!resetn)
		err_report.nonfatal && !err_report.fatal |->
		err_class == PEDC_CLS_NONFATAL)
		else $error("non-fatal class wrong");

	class_cor_a: assert property (
		@(posedge clk) disable iff (!resetn)
		err_report.cor && !err_report.nonfatal && !err_report.fatal |->
		err_class == PEDC_CLS_COR)
		else $error("correctable class wrong");

	class_none_a: assert property (
		@(posedge clk) disable iff (!resetn)
		err_class == PEDC_CLS_NONE |->
		!err_report.cor && !err_report.nonfatal && !err_report.fatal)
		else $error("report without class");

	class_sticky_a: assert property (
		@(posedge clk) disable iff (!resetn)
		({err_report.fatal, err_report.nonfatal, err_report.cor} &
		~class_status) == 3'h0)
		else $error("class summary missed a report");
endmodule

// ==== pedc_app_model.sv ====
// application-side model that consumes delivered receive packets
`timescale 1ns/1ps
module pedc_app_model
	import pedc_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire pedc_pkg::pedc_rx_pkt_t rx_pkt,
	output logic [7:0] poison_cnt_r,
	output logic [63:0] last_good_r
);
	import pedc_pkg::*;
	logic [7:0] poison_cnt_nxt;
	logic [63:0] last_good_nxt;
	// ============================================================
	// poisoned beats dropped and counted, so bad data never reaches use
	always_comb begin
		poison_cnt_nxt = poison_cnt_r;
		last_good_nxt = last_good_r;
		if (rx_pkt.valid && rx_pkt.poisoned) begin
			poison_cnt_nxt = poison_cnt_r + 8'h01;
		end else if (rx_pkt.valid) begin
			last_good_nxt = rx_pkt.data;
		end
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			poison_cnt_r <= 8'h00;
			last_good_r <= 64'h0;
		end else begin
			poison_cnt_r <= poison_cnt_nxt;
			last_good_r <= last_good_nxt;
		end
	end
endmodule

// ==== tb_pedc_classifier.sv ====
// self-checking bench for the link error classifier
`timescale 1ns/1ps
module tb_pedc_classifier;
	import pedc_pkg::*;
	logic clk, resetn, deskew_overflow;
	logic [11:0] rx_status, acked_seq, next_tx_seq;
	logic [3:0] lane_in_l0, ctl_sym_bad_lane;
	pedc_ltssm_t ltssm_state;
	pedc_dll_ev_t dll_ev;
	pedc_rx_pkt_t rx_pkt_in, rx_pkt_out, pkt;
	logic [9:0] err_clear, err_status;
	pedc_report_t err_report;
	pedc_class_t err_class;
	logic [2:0] class_status;
	logic [7:0] poison_cnt;
	logic [63:0] last_good;
	int bad_count, check_count;
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	pedc_classifier u_dut(.clk(clk), .resetn(resetn), .rx_status(rx_status),
		.lane_in_l0(lane_in_l0), .deskew_overflow(deskew_overflow),
		.ctl_sym_bad_lane(ctl_sym_bad_lane), .ltssm_state(ltssm_state),
		.dll_ev(dll_ev), .acked_seq(acked_seq), .next_tx_seq(next_tx_seq),
		.rx_pkt_in(rx_pkt_in), .err_clear(err_clear), .rx_pkt_out(rx_pkt_out),
		.err_report(err_report), .err_class(err_class),
		.err_status(err_status), .class_status(class_status));
	pedc_app_model u_app(.clk(clk), .resetn(resetn), .rx_pkt(rx_pkt_out),
		.poison_cnt_r(poison_cnt), .last_good_r(last_good));
	// ============================================================
	// shared tasks
	task chk(string name, logic [63:0] seen, logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	task idle();
		rx_status <= 12'h000;
		lane_in_l0 <= 4'hF;
		deskew_overflow <= 1'b0;
		ctl_sym_bad_lane <= 4'h0;
		ltssm_state <= PEDC_LT_L0;
		dll_ev <= '0;
		rx_pkt_in <= '0;
		err_clear <= 10'h000;
	endtask
	// inputs set before this edge are sampled at it; look once settled
	task sample();
		@(posedge clk);
		idle();
		#1;
	endtask
	task wipe();
		@(posedge clk);
		err_clear <= 10'h3FF;
		sample();
	endtask
	task ev(string n, logic [2:0] rep, logic [1:0] cls, logic [9:0] st);
		chk({n, " report"}, err_report, rep);
		chk({n, " class"}, err_class, cls);
		chk({n, " status"}, err_status, st);
	endtask
	// ============================================================
	// scenarios
	task t_phys();
		for (int i = 0; i < 4; i++) begin
			wipe();
			@(posedge clk);
			rx_status[3*i +: 3] <= 3'h4 + 3'(i);
			sample();
			ev("lane code", 3'h4, 2'h1, 10'h001);
		end
		wipe();
		@(posedge clk);
		rx_status <= 12'hF3B;
		lane_in_l0 <= 4'h1;
		sample();
		ev("lane gated", 3'h0, 2'h0, 10'h000);
		@(posedge clk);
		deskew_overflow <= 1'b1;
		sample();
		ev("deskew", 3'h4, 2'h1, 10'h101);
		wipe();
		@(posedge clk);
		ctl_sym_bad_lane <= 4'h8;
		sample();
		ev("ctl symbol", 3'h4, 2'h1, 10'h201);
	endtask
	task t_train();
		pedc_ltssm_t ok [4];
		ok = '{PEDC_LT_HOTRESET, PEDC_LT_DISABLE, PEDC_LT_LOOPBACK, PEDC_LT_L2};
		wipe();
		@(posedge clk);
		ltssm_state <= PEDC_LT_DETECT;
		sample();
		ev("train", 3'h1, 2'h3, 10'h040);
		chk("train class", class_status, 3'h4);
		for (int i = 0; i < 4; i++) begin
			wipe();
			@(posedge clk);
			ltssm_state <= ok[i];
			@(posedge clk);
			ltssm_state <= PEDC_LT_DETECT;
			sample();
			ev("train legal", 3'h0, 2'h0, 10'h000);
		end
	endtask
	task t_dll();
		logic [11:0] a [4];
		logic [9:0] st;
		logic f;
		a = '{12'h002, 12'hFFE, 12'h003, 12'hFFD};
		for (int i = 0; i < 5; i++) begin
			st = 10'h001 << (i == 0 ? 1 : i);
			wipe();
			@(posedge clk);
			dll_ev <= {5'h10 >> i, 13'h0000};
			sample();
			ev("dll", 3'h4, 2'h1, st);
		end
		@(posedge clk);
		acked_seq <= 12'hFFE;
		next_tx_seq <= 12'h003;
		for (int i = 0; i < 4; i++) begin
			f = (i > 1);
			wipe();
			@(posedge clk);
			dll_ev <= {6'h01, a[i]};
			sample();
			ev("ack", {2'h0, f}, {f, f}, {2'h0, f, 7'h00});
		end
	endtask
	task t_poison();
		wipe();
		pkt = {2'h3, 64'hA5A5, 64'h1234};
		@(posedge clk);
		rx_pkt_in <= pkt;
		sample();
		ev("poison", 3'h2, 2'h2, 10'h020);
		chk("poison vp", {rx_pkt_out.valid, rx_pkt_out.poisoned}, 2'h3);
		chk("poison desc", rx_pkt_out.desc, pkt.desc);
		chk("poison data", rx_pkt_out.data, pkt.data);
		chk("class sticky", class_status, 3'h2);
		pkt = {2'h2, 64'h0, 64'h77};
		@(posedge clk);
		rx_pkt_in <= pkt;
		sample();
		chk("clean vp", {rx_pkt_out.valid, rx_pkt_out.poisoned}, 2'h2);
		chk("clean data", rx_pkt_out.data, pkt.data);
		sample();
		chk("app count", poison_cnt, 8'h01);
		chk("app data", last_good, 64'h77);
	endtask
	task t_sticky();
		wipe();
		@(posedge clk);
		deskew_overflow <= 1'b1;
		dll_ev.dllp_crc_bad <= 1'b1;
		sample();
		repeat (3) @(posedge clk);
		#1;
		chk("held", {class_status, err_status}, {3'h1, 10'h105});
		@(posedge clk);
		err_clear <= 10'h004;
		sample();
		chk("part clear", {class_status, err_status}, {3'h1, 10'h101});
		@(posedge clk);
		dll_ev.dllp_crc_bad <= 1'b1;
		err_clear <= 10'h31F;
		sample();
		chk("set wins", {class_status, err_status}, {3'h1, 10'h004});
		@(posedge clk);
		err_clear <= 10'h31F;
		sample();
		chk("all clear", {class_status, err_status}, 13'h0000);
	endtask
	task results();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// ============================================================
	// main sequence and watchdog
	initial begin
		repeat (5000) @(posedge clk);
		bad_count++;
		results();
	end
	initial begin
		bad_count = 0;
		check_count = 0;
		resetn = 1'b0;
		acked_seq = 12'h000;
		next_tx_seq = 12'h000;
		idle();
		repeat (10) @(posedge clk);
		chk("reset", {class_status, err_status}, 13'h0000);
		resetn <= 1'b1;
		t_phys();
		t_train();
		t_dll();
		t_poison();
		t_sticky();
		results();
	end
endmodule
